// ==== rtl/mie_exec.sv ====
// Purpose: executes six instructions of an 8-bit core
// Assumes: op and operands are held valid for one cycle while busy is low
// Notes: rom data returns combinationally for the address driven out
// Notes: a file write still in flight is forwarded to a following xor
`timescale 1ns/1ps
`default_nettype none
`include "mie_cfg.svh"
module mie_exec (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [2:0] op,
  input wire logic [7:0] literal,
  input wire logic [5:0] file_sel,
  input wire logic dest_file,
  input wire logic [2:0] table_page_pointer,
  input wire logic [13:0] rom_data,
  output logic [10:0] rom_addr,
  output logic [7:0] work_register,
  output logic [7:0] timer_mode_register,
  output logic [7:0] table_high_byte,
  output logic zero_flag,
  output logic nibble_carry_flag,
  output logic carry_flag,
  output logic busy,
  output logic file_we,
  output logic [5:0] file_addr,
  output logic [7:0] file_wdata
);
  mie_pkg::mie_state_s cur; // registered state
  mie_pkg::mie_state_s next_cur; // next state
  logic [7:0] file_rdata; // addressed file value
  logic [8:0] diff; // literal minus work with carry
  logic [4:0] ndiff; // low nibble difference
  logic [7:0] xres; // xor result
  logic [7:0] file_val; // file value with pending write forwarded

  // zero test shared by every result that sets the zero flag
  function automatic logic zero_of(input logic [7:0] value);
    zero_of = (value == 8'h00);
  endfunction : zero_of

  // file registers, written one cycle after the instruction
  mie_file_regs u_file (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .we(cur.file_we),
    .waddr(cur.file_addr),
    .wdata(cur.file_wdata),
    .raddr(file_sel),
    .rdata(file_rdata)
  );

  // next state logic
  always_comb begin
    next_cur = cur;
    next_cur.file_we = 1'b0;
    diff = {1'b0, literal} + {1'b0, ~cur.work} + 9'h001;
    ndiff = {1'b0, literal[3:0]} + {1'b0, ~cur.work[3:0]} + 5'h01;
    xres = 8'h00;
    // storage lags the write pulse by one edge, so a pending write wins
    if (cur.file_we && (cur.file_addr == file_sel)) begin
      file_val = cur.file_wdata; // back to back xor on one index [RL8]
    end else begin
      file_val = file_rdata;
    end

    case (cur.state)
      mie_pkg::MIE_IDLE: begin
        case (op)
          `MIE_OP_IMM_MINUS_WORK: begin
            next_cur.work = diff[7:0]; // [RL1]
            next_cur.carry = diff[8]; // no borrow gives one [RL2]
            next_cur.nibble_carry = ndiff[4]; // [RL1]
            next_cur.zero = zero_of(diff[7:0]); // [RL10]
          end
          `MIE_OP_PROGRAM_ROM_READ: begin
            next_cur.rom_addr = {table_page_pointer, cur.work}; // [RL3]
            next_cur.busy = 1'b1;
            next_cur.state = mie_pkg::MIE_ROM_WAIT;
          end
          `MIE_OP_WRITE_TIMER_MODE: begin
            next_cur.timer_mode = cur.work; // [RL5]
          end
          `MIE_OP_READ_TIMER_MODE: begin
            next_cur.work = cur.timer_mode; // flags untouched [RL6]
          end
          `MIE_OP_XOR_WORK_WITH_FILE: begin
            xres = cur.work ^ file_val;
            next_cur.zero = zero_of(xres); // [RL7]
            if (dest_file) begin
              next_cur.file_we = 1'b1; // [RL8]
              next_cur.file_addr = file_sel;
              next_cur.file_wdata = xres;
            end else begin
              next_cur.work = xres; // [RL7]
            end
          end
          `MIE_OP_XOR_WORK_WITH_LITERAL: begin
            xres = cur.work ^ literal;
            next_cur.work = xres; // [RL9]
            next_cur.zero = zero_of(xres); // [RL10]
          end
          default: begin
            next_cur.busy = 1'b0; // no operation
          end
        endcase
      end
      mie_pkg::MIE_ROM_WAIT: begin
        next_cur.work = rom_data[7:0]; // [RL3]
        next_cur.table_high = rom_data[13:8]; // [RL4]
        next_cur.busy = 1'b0;
        next_cur.state = mie_pkg::MIE_IDLE;
      end
      default: begin
        next_cur.state = mie_pkg::MIE_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '{state: mie_pkg::MIE_IDLE, work: `MIE_RST_WORK,
        timer_mode: `MIE_RST_TIMER_MODE, table_high: `MIE_RST_TABLE_HIGH,
        zero: 1'b0, nibble_carry: 1'b0, carry: 1'b0, busy: 1'b0,
        rom_addr: 11'h000, file_we: 1'b0, file_addr: 6'h00, file_wdata: 8'h00};
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from state
  assign rom_addr = cur.rom_addr;
  assign work_register = cur.work;
  assign timer_mode_register = cur.timer_mode;
  assign table_high_byte = {2'b00, cur.table_high};
  assign zero_flag = cur.zero;
  assign nibble_carry_flag = cur.nibble_carry;
  assign carry_flag = cur.carry;
  assign busy = cur.busy;
  assign file_we = cur.file_we;
  assign file_addr = cur.file_addr;
  assign file_wdata = cur.file_wdata;

  // subtract result and borrow
  sub_result_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL2]
    (cur.state == mie_pkg::MIE_IDLE && op == `MIE_OP_IMM_MINUS_WORK) |=>
    (work_register == 8'($past(literal) - $past(cur.work))) &&
    (carry_flag == ($past(literal) >= $past(cur.work))))
    else $error("subtract result or carry wrong");

  // subtract nibble carry and zero flag
  sub_flags_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL1]
    (cur.state == mie_pkg::MIE_IDLE && op == `MIE_OP_IMM_MINUS_WORK) |=>
    (nibble_carry_flag == (($past(literal) & 8'h0f) >= ($past(cur.work) & 8'h0f))) &&
    (zero_flag == (work_register == 8'h00)))
    else $error("subtract nibble carry or zero wrong");

  // rom read takes two cycles at page and work
  rom_two_cycle_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL3]
    (cur.state == mie_pkg::MIE_IDLE && op == `MIE_OP_PROGRAM_ROM_READ) |=>
    (busy && (rom_addr == {$past(table_page_pointer), $past(cur.work)})) ##1
    (!busy && (work_register == 8'($past(rom_data)))))
    else $error("rom read timing or data wrong");

  // upper six rom bits land in table high byte
  rom_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL4]
    (cur.state == mie_pkg::MIE_ROM_WAIT) |=>
    (table_high_byte == {2'b00, 6'($past(rom_data) >> 8)}))
    else $error("table high byte wrong");

  // rom read keeps flags
  rom_flags_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL10]
    (cur.state == mie_pkg::MIE_ROM_WAIT) |=> $stable({zero_flag, carry_flag,
    nibble_carry_flag}))
    else $error("rom read changed flags");

  // ops offered while busy are ignored
  busy_ignore_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL3]
    (cur.state == mie_pkg::MIE_ROM_WAIT) |=>
    !busy && !file_we && $stable(timer_mode_register))
    else $error("op taken while busy");

  // timer mode write
  timer_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL5]
    (cur.state == mie_pkg::MIE_IDLE && op == `MIE_OP_WRITE_TIMER_MODE) |=>
    (timer_mode_register == $past(cur.work)) && $stable(work_register) &&
    $stable({zero_flag, carry_flag, nibble_carry_flag}))
    else $error("timer mode write wrong");

  // timer mode read
  timer_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL6]
    (cur.state == mie_pkg::MIE_IDLE && op == `MIE_OP_READ_TIMER_MODE) |=>
    (work_register == $past(cur.timer_mode)) &&
    $stable({zero_flag, carry_flag, nibble_carry_flag}))
    else $error("timer mode read wrong");

  // xor to file destination
  xor_file_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL8]
    (cur.state == mie_pkg::MIE_IDLE && op == `MIE_OP_XOR_WORK_WITH_FILE && dest_file)
    |=> file_we && $stable(work_register) && (file_addr == $past(file_sel)) &&
    (file_wdata == ($past(cur.work) ^ $past(file_val))))
    else $error("xor file write missing");

  // back to back xor into one index sees the pending write
  xor_forward_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL8]
    (cur.state == mie_pkg::MIE_IDLE && op == `MIE_OP_XOR_WORK_WITH_FILE && dest_file &&
    file_we && (file_addr == file_sel)) |=>
    (file_wdata == ($past(cur.work) ^ $past(file_wdata))))
    else $error("xor file forward wrong");

  // xor to work destination
  xor_work_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL7]
    (cur.state == mie_pkg::MIE_IDLE && op == `MIE_OP_XOR_WORK_WITH_FILE && !dest_file)
    |=> !file_we && (work_register == ($past(cur.work) ^ $past(file_val))) &&
    $stable({carry_flag, nibble_carry_flag}))
    else $error("xor work destination wrong");

  // xor literal and zero flag
  xor_lit_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL9]
    (cur.state == mie_pkg::MIE_IDLE && op == `MIE_OP_XOR_WORK_WITH_LITERAL) |=>
    (work_register == ($past(cur.work) ^ $past(literal))) &&
    (zero_flag == (work_register == 8'h00)) && $stable({carry_flag, nibble_carry_flag}))
    else $error("xor literal wrong");
endmodule : mie_exec
`default_nettype wire

// ==== rtl/mie_cfg.svh ====
// Purpose: constants for the instruction execution subset
// Assumes: 8-bit data path, 14-bit program words, 64 file registers
// Notes: opcode codes are local to this block
// Functional notes
// (RL1) literal minus work into work, flags updated
// (RL2) carry is zero when a borrow occurs
// (RL3) rom read at pointer and work, two cycles
// (RL4) upper six rom bits into table high byte
// (RL5) work copied into timer mode register
// (RL6) timer mode copied to work, one cycle
// (RL7) xor with file, d zero to work
// (RL8) xor with file, d one to file
// (RL9) xor literal into work, zero flag only
// (RL10) zero flag on zero result; transfers keep flags
`ifndef MIE_CFG_SVH
`define MIE_CFG_SVH
`define MIE_OP_NONE 3'h0
`define MIE_OP_IMM_MINUS_WORK 3'h1
`define MIE_OP_PROGRAM_ROM_READ 3'h2
`define MIE_OP_WRITE_TIMER_MODE 3'h3
`define MIE_OP_READ_TIMER_MODE 3'h4
`define MIE_OP_XOR_WORK_WITH_FILE 3'h5
`define MIE_OP_XOR_WORK_WITH_LITERAL 3'h6
`define MIE_RST_WORK 8'h00
`define MIE_RST_TIMER_MODE 8'h00
`define MIE_RST_TABLE_HIGH 6'h00
`define MIE_FILE_DEPTH 64
`define MIE_ROM_CYCLES 2
`endif

// ==== rtl/mie_pkg.sv ====
// Purpose: types for the instruction execution subset
// Assumes: constants come from mie_cfg.svh
// Notes: sequencer state and block state record
package mie_pkg;
  typedef enum logic [0:0] {
    MIE_IDLE = 1'b0,
    MIE_ROM_WAIT = 1'b1
  } mie_state_e;
  typedef struct packed {
    mie_state_e state;
    logic [7:0] work;
    logic [7:0] timer_mode;
    logic [5:0] table_high;
    logic zero;
    logic nibble_carry;
    logic carry;
    logic busy;
    logic [10:0] rom_addr;
    logic file_we;
    logic [5:0] file_addr;
    logic [7:0] file_wdata;
  } mie_state_s;
endpackage : mie_pkg

// ==== rtl/mie_file_regs.sv ====
// Purpose: 64 file registers held in flip-flops
// Assumes: one write port, one combinational read port
// Notes: registered write, read has no latency
`timescale 1ns/1ps
`default_nettype none
`include "mie_cfg.svh"
module mie_file_regs (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [5:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:`MIE_FILE_DEPTH-1]; // file storage
  // storage write, cleared at reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `MIE_FILE_DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end
  // combinational read
  assign rdata = mem[raddr];
endmodule : mie_file_regs
`default_nettype wire

// ==== bench/mie_exec_tb.sv ====
// Purpose: self-checking bench for the six-instruction execution block
// Assumes: work starts at zero after reset, so xor with a literal loads it
// Notes: inputs move on the falling edge, results are read on the next falling edge
`timescale 1ns/1ps
`default_nettype none
`include "mie_cfg.svh"
module testbench;
  logic clk_sys, reset_n, dest_file, busy, file_we, zero_flag, nibble_carry_flag, carry_flag;
  logic [2:0] op, table_page_pointer;
  logic [7:0] literal, work_register, timer_mode_register, table_high_byte, file_wdata;
  logic [5:0] file_sel, file_addr;
  logic [13:0] rom_data;
  logic [10:0] rom_addr;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  mie_exec dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .op(op), .literal(literal),
    .file_sel(file_sel), .dest_file(dest_file), .table_page_pointer(table_page_pointer),
    .rom_data(rom_data), .rom_addr(rom_addr), .work_register(work_register),
    .timer_mode_register(timer_mode_register), .table_high_byte(table_high_byte),
    .zero_flag(zero_flag), .nibble_carry_flag(nibble_carry_flag), .carry_flag(carry_flag),
    .busy(busy), .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata));
  // 40 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 500) begin
      n_errors++;
      final_report();
    end
  end
  // compare one value, four-state exact
  task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // issue one op for one cycle, return once results are visible
  task automatic exec(input logic [2:0] o, input logic [7:0] l, input logic [5:0] s,
                      input logic d);
    @(negedge clk_sys);
    op = o;
    literal = l;
    file_sel = s;
    dest_file = d;
    @(negedge clk_sys);
    op = 3'h0;
  endtask : exec
  // subtract with and without borrow
  task automatic test_sub();
    exec(`MIE_OP_XOR_WORK_WITH_LITERAL, 8'h06, 6'h00, 1'b0);
    chk("work", 14'h0006, work_register);
    exec(`MIE_OP_IMM_MINUS_WORK, 8'h05, 6'h00, 1'b0);
    chk("work", 14'h00ff, work_register);
    chk("carry", 14'h0, carry_flag);
    chk("nibble", 14'h0, nibble_carry_flag);
    exec(`MIE_OP_XOR_WORK_WITH_LITERAL, 8'hfa, 6'h00, 1'b0);
    chk("carry kept", 14'h0, carry_flag);
    exec(`MIE_OP_IMM_MINUS_WORK, 8'h06, 6'h00, 1'b0);
    chk("work", 14'h0001, work_register);
    chk("carry", 14'h1, carry_flag);
    chk("nibble", 14'h1, nibble_carry_flag);
    chk("zero", 14'h0, zero_flag);
    $display("test_sub done");
  endtask : test_sub
  // timer mode write then read back
  task automatic test_timer();
    exec(`MIE_OP_XOR_WORK_WITH_LITERAL, 8'hab, 6'h00, 1'b0);
    exec(`MIE_OP_WRITE_TIMER_MODE, 8'h00, 6'h00, 1'b0);
    chk("timer", 14'h00aa, timer_mode_register);
    chk("work", 14'h00aa, work_register);
    exec(`MIE_OP_XOR_WORK_WITH_LITERAL, 8'haa, 6'h00, 1'b0);
    chk("zero", 14'h1, zero_flag);
    exec(`MIE_OP_READ_TIMER_MODE, 8'h00, 6'h00, 1'b0);
    chk("work", 14'h00aa, work_register);
    chk("zero kept", 14'h1, zero_flag);
    $display("test_timer done");
  endtask : test_timer
  // xor with file, to file then to work
  task automatic test_xor_file();
    exec(`MIE_OP_XOR_WORK_WITH_LITERAL, 8'h5a, 6'h00, 1'b0);
    exec(`MIE_OP_XOR_WORK_WITH_FILE, 8'h00, 6'h3f, 1'b1);
    chk("we", 14'h1, file_we);
    chk("addr", 14'h003f, file_addr);
    chk("wdata", 14'h00f0, file_wdata);
    chk("work", 14'h00f0, work_register);
    exec(`MIE_OP_XOR_WORK_WITH_FILE, 8'h00, 6'h3f, 1'b0);
    chk("we", 14'h0, file_we);
    chk("work", 14'h0000, work_register);
    chk("zero", 14'h1, zero_flag);
    chk("carry kept", 14'h1, carry_flag);
    $display("test_xor_file done");
  endtask : test_xor_file
  // two-cycle rom read
  task automatic test_rom();
    exec(`MIE_OP_XOR_WORK_WITH_LITERAL, 8'h34, 6'h00, 1'b0);
    table_page_pointer = 3'h2;
    exec(`MIE_OP_PROGRAM_ROM_READ, 8'h00, 6'h00, 1'b0);
    chk("rom addr", 14'h0234, rom_addr);
    chk("busy", 14'h1, busy);
    rom_data = 14'h35aa;
    @(negedge clk_sys);
    rom_data = 14'h0a55;
    chk("busy", 14'h0, busy);
    chk("work", 14'h00aa, work_register);
    chk("table", 14'h0035, table_high_byte);
    chk("zero kept", 14'h0, zero_flag);
    $display("test_rom done");
  endtask : test_rom
  // back to back xor into one file register, the second sees the first
  task automatic test_b2b();
    exec(`MIE_OP_XOR_WORK_WITH_LITERAL, 8'h96, 6'h00, 1'b0);
    chk("work", 14'h003c, work_register);
    @(negedge clk_sys);
    op = `MIE_OP_XOR_WORK_WITH_FILE;
    file_sel = 6'h10;
    dest_file = 1'b1;
    @(negedge clk_sys);
    chk("wdata", 14'h003c, file_wdata);
    @(negedge clk_sys);
    op = 3'h0;
    chk("wdata", 14'h0000, file_wdata);
    chk("zero", 14'h1, zero_flag);
    chk("work", 14'h003c, work_register);
    $display("test_b2b done");
  endtask : test_b2b
  // ops during busy and the spare code leave state alone
  task automatic test_refuse();
    @(negedge clk_sys);
    op = `MIE_OP_PROGRAM_ROM_READ;
    @(negedge clk_sys);
    chk("rom addr", 14'h023c, rom_addr);
    chk("busy", 14'h1, busy);
    op = `MIE_OP_XOR_WORK_WITH_LITERAL;
    literal = 8'hff;
    rom_data = 14'h0155;
    @(negedge clk_sys);
    op = 3'h7;
    chk("work", 14'h0055, work_register);
    chk("table", 14'h0001, table_high_byte);
    chk("busy", 14'h0, busy);
    @(negedge clk_sys);
    op = 3'h0;
    chk("work", 14'h0055, work_register);
    chk("zero kept", 14'h1, zero_flag);
    $display("test_refuse done");
  endtask : test_refuse
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    reset_n = 1'b0;
    op = 3'h0;
    literal = 8'h00;
    file_sel = 6'h00;
    dest_file = 1'b0;
    table_page_pointer = 3'h0;
    rom_data = 14'h0000;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    test_sub();
    test_timer();
    test_xor_file();
    test_rom();
    test_b2b();
    test_refuse();
    final_report();
  end
endmodule : testbench
`default_nettype wire
